// ===== rmu_top.sv
// Purpose: Rotate and mask execution unit behind an AXI4-Lite slave
// Assumes: Single clock aclk, synchronous active-low aresetn
// Notes: Writing the control word with go set launches one operation
`timescale 1ns/100ps

// Behaviour
// - Doubleword immediate clear-left rotates left, masks begin through bit 63.
// - Doubleword immediate clear-right rotates left, masks bit 0 through end.
// - Doubleword immediate clear masks begin through 63 minus count.
// - Word immediate AND-mask masks begin plus 32 through end plus 32.
// - Doubleword register clear-left rotates by six count bits, masks begin to 63.
// - Doubleword register clear-right rotates by six count bits, masks 0 to end.
// - Word register AND-mask rotates by five count bits, word mask.
// - Word immediate insert replaces destination bits only under the word mask.
// - Doubleword immediate insert replaces destination bits under begin..63-count mask.
// - Record flag updates first condition field; otherwise condition field kept.
// - Algebraic shift carry is computed the same in both modes.
// - Doubleword rotate is circular across all 64 bits.
// - Word rotate uses two copies of the low 32 source bits.
// - Begin above end gives a wrapped mask of ones.
// - Recording sets condition bits 0..2 and copies sum_ovf into bit 3; carry untouched.
module rmu_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [rmu_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rmu_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Position p counts from the msb, so vector index is 63 - p
    function automatic logic [63:0] gen_mask(input logic [5:0] b, input logic [5:0] e);
        logic [63:0] m;
        logic hit;
        m = 64'h0000000000000000;
        for (int p = 0; p < 64; p++) begin
            if (b <= e) begin
                hit = (6'(p) >= b) && (6'(p) <= e);
            end else begin
                hit = (6'(p) >= b) || (6'(p) <= e); // Wrapped form
            end
            m[63-p] = hit;
        end
        return m;
    endfunction

    // Left rotation toward bit 0; bits leaving 0 come back at 63
    function automatic logic [63:0] rotl64(input logic [63:0] x, input logic [5:0] n);
        logic [127:0] t;
        t = {x, x} << n;
        return t[127:64];
    endfunction

    function automatic logic mapped(input logic [rmu_pkg::ADDR_W-1:0] a);
        return a == rmu_pkg::OFS_CTRL || a == rmu_pkg::OFS_FIELDS ||
               a == rmu_pkg::OFS_SRC_LO || a == rmu_pkg::OFS_SRC_HI ||
               a == rmu_pkg::OFS_COUNT || a == rmu_pkg::OFS_DEST_LO ||
               a == rmu_pkg::OFS_DEST_HI || a == rmu_pkg::OFS_RES_LO ||
               a == rmu_pkg::OFS_RES_HI || a == rmu_pkg::OFS_STATUS;
    endfunction

    // ----------------------------------------
    // Bus slave state
    // ----------------------------------------
    logic awready_ff, wready_ff, aw_have_ff, w_have_ff, pend_ff, bvalid_ff;
    logic [1:0] bresp_ff, pend_resp_ff, rresp_ff;
    logic [rmu_pkg::ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic arready_ff, rvalid_ff;
    logic [31:0] rdata_ff;

    logic [31:0] ctrl_ff, fields_ff, src_lo_ff, src_hi_ff, count_ff, dest_lo_ff, dest_hi_ff;
    logic [63:0] result_ff;
    logic [3:0] cond_ff;
    logic carry_ff, exec_ff;

    wire aw_hs = s_axi_awvalid & awready_ff;
    wire w_hs = s_axi_wvalid & wready_ff;
    wire b_hs = bvalid_ff & s_axi_bready;
    wire ar_hs = s_axi_arvalid & arready_ff;
    wire r_hs = rvalid_ff & s_axi_rready;
    wire wr_fire = aw_have_ff & w_have_ff;
    wire [31:0] wr_word = merge_strb(32'h00000000, wdata_ff, wstrb_ff);
    wire wr_mapped = mapped(awaddr_ff);
    wire sel_ctrl = wr_fire && awaddr_ff == rmu_pkg::OFS_CTRL;
    wire sel_fields = wr_fire && awaddr_ff == rmu_pkg::OFS_FIELDS;
    wire sel_src_lo = wr_fire && awaddr_ff == rmu_pkg::OFS_SRC_LO;
    wire sel_src_hi = wr_fire && awaddr_ff == rmu_pkg::OFS_SRC_HI;
    wire sel_count = wr_fire && awaddr_ff == rmu_pkg::OFS_COUNT;
    wire sel_dest_lo = wr_fire && awaddr_ff == rmu_pkg::OFS_DEST_LO;
    wire sel_dest_hi = wr_fire && awaddr_ff == rmu_pkg::OFS_DEST_HI;
    wire go_req = sel_ctrl & wstrb_ff[1] & wr_word[rmu_pkg::CTRL_GO_BIT];

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    // Ready drops once a beat is held, so only one write is in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            pend_ff <= 1'b0;
            pend_resp_ff <= rmu_pkg::RESP_OKAY;
            bvalid_ff <= 1'b0;
            bresp_ff <= rmu_pkg::RESP_OKAY;
            awaddr_ff <= '0;
            wdata_ff <= rmu_pkg::WORD_RST;
            wstrb_ff <= 4'h0;
        end else begin
            if (aw_hs) begin
                awready_ff <= 1'b0;
                aw_have_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                wready_ff <= 1'b0;
                w_have_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                pend_resp_ff <= wr_mapped ? rmu_pkg::RESP_OKAY : rmu_pkg::RESP_SLVERR;
            end
            pend_ff <= wr_fire;
            // Response waits one cycle so a launched result is already stored
            if (pend_ff) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= pend_resp_ff;
            end else if (b_hs) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= rmu_pkg::CTRL_RST;
            fields_ff <= rmu_pkg::FIELDS_RST;
            src_lo_ff <= rmu_pkg::WORD_RST;
            src_hi_ff <= rmu_pkg::WORD_RST;
            count_ff <= rmu_pkg::WORD_RST;
            dest_lo_ff <= rmu_pkg::WORD_RST;
            dest_hi_ff <= rmu_pkg::WORD_RST;
            exec_ff <= 1'b0;
        end else begin
            if (sel_ctrl) begin
                ctrl_ff <= merge_strb(ctrl_ff, wdata_ff, wstrb_ff) & rmu_pkg::CTRL_STORE_MASK;
            end
            if (sel_fields) begin
                fields_ff <= merge_strb(fields_ff, wdata_ff, wstrb_ff) &
                             rmu_pkg::FIELDS_STORE_MASK;
            end
            if (sel_src_lo) src_lo_ff <= merge_strb(src_lo_ff, wdata_ff, wstrb_ff);
            if (sel_src_hi) src_hi_ff <= merge_strb(src_hi_ff, wdata_ff, wstrb_ff);
            if (sel_count) count_ff <= merge_strb(count_ff, wdata_ff, wstrb_ff);
            if (sel_dest_lo) dest_lo_ff <= merge_strb(dest_lo_ff, wdata_ff, wstrb_ff);
            if (sel_dest_hi) dest_hi_ff <= merge_strb(dest_hi_ff, wdata_ff, wstrb_ff);
            exec_ff <= go_req;
        end
    end

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    rmu_pkg::rmu_ctrl_t ctrl;
    rmu_pkg::rmu_fields_t flds;
    assign ctrl = rmu_pkg::rmu_ctrl_t'(ctrl_ff);
    assign flds = rmu_pkg::rmu_fields_t'(fields_ff);

    wire [63:0] src = {src_hi_ff, src_lo_ff};
    wire [63:0] dest = {dest_hi_ff, dest_lo_ff};
    wire [5:0] imm_cnt = flds.rotate_count;
    wire [5:0] reg_cnt6 = count_ff[5:0];
    wire [5:0] reg_cnt5 = {1'b0, count_ff[4:0]};
    wire [5:0] wimm_cnt = {1'b0, imm_cnt[4:0]};
    wire [5:0] mb = flds.mask_begin;
    wire [5:0] me = flds.mask_end;
    wire [5:0] mb_w = rmu_pkg::WORD_BIAS | {1'b0, mb[4:0]};
    wire [5:0] me_w = rmu_pkg::WORD_BIAS | {1'b0, me[4:0]};
    wire [5:0] stop_dw = rmu_pkg::LAST_BIT - imm_cnt;
    wire [63:0] word_pair = {src_lo_ff, src_lo_ff};

    wire [63:0] rot_dw_imm = rotl64(src, imm_cnt);
    wire [63:0] rot_dw_reg = rotl64(src, reg_cnt6);
    wire [63:0] rot_w_imm = rotl64(word_pair, wimm_cnt);
    wire [63:0] rot_w_reg = rotl64(word_pair, reg_cnt5);

    wire [63:0] m_left = gen_mask(mb, rmu_pkg::LAST_BIT);
    wire [63:0] m_right = gen_mask(6'h00, me);
    wire [63:0] m_clr = gen_mask(mb, stop_dw);
    wire [63:0] m_word = gen_mask(mb_w, me_w);

    // Algebraic shift: carry only when negative and ones leave the low end
    wire [63:0] sra_val = 64'($signed(src) >>> imm_cnt);
    wire [63:0] lost_bits = src & ~(64'hFFFFFFFFFFFFFFFF << imm_cnt);
    wire sra_carry = src[63] & (|lost_bits);

    logic [63:0] nxt_result;
    logic op_valid;
    always_comb begin
        op_valid = 1'b1;
        nxt_result = result_ff;
        unique case (ctrl.op)
            rmu_pkg::RMU_OP_DW_IMM_CLR_LEFT: nxt_result = rot_dw_imm & m_left;
            rmu_pkg::RMU_OP_DW_IMM_CLR_RIGHT: nxt_result = rot_dw_imm & m_right;
            rmu_pkg::RMU_OP_DW_IMM_CLR: nxt_result = rot_dw_imm & m_clr;
            rmu_pkg::RMU_OP_W_IMM_AND_MASK: nxt_result = rot_w_imm & m_word;
            rmu_pkg::RMU_OP_DW_REG_CLR_LEFT: nxt_result = rot_dw_reg & m_left;
            rmu_pkg::RMU_OP_DW_REG_CLR_RIGHT: nxt_result = rot_dw_reg & m_right;
            rmu_pkg::RMU_OP_W_REG_AND_MASK: nxt_result = rot_w_reg & m_word;
            rmu_pkg::RMU_OP_W_IMM_INSERT: begin
                nxt_result = (rot_w_imm & m_word) | (dest & ~m_word);
            end
            rmu_pkg::RMU_OP_DW_IMM_INSERT: begin
                nxt_result = (rot_dw_imm & m_clr) | (dest & ~m_clr);
            end
            rmu_pkg::RMU_OP_SHR_ALG_DW_IMM: nxt_result = sra_val;
            default: op_valid = 1'b0;
        endcase
    end

    // Compare width follows the mode; carry never does
    wire sign_bit = ctrl.mode64 ? nxt_result[63] : nxt_result[31];
    wire is_zero = ctrl.mode64 ? (nxt_result == 64'h0000000000000000) :
                                 (nxt_result[31:0] == 32'h00000000);
    rmu_pkg::rmu_cond_t nxt_cond;
    assign nxt_cond = '{lt: sign_bit, gt: ~sign_bit & ~is_zero, eq: is_zero,
                        so: ctrl.sum_ovf};

    // Illegal op codes leave every result register untouched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_ff <= 64'h0000000000000000;
            cond_ff <= rmu_pkg::COND_RST;
            carry_ff <= 1'b0;
        end else if (exec_ff && op_valid) begin
            result_ff <= nxt_result;
            if (ctrl.record) cond_ff <= nxt_cond;
            if (ctrl.op == rmu_pkg::RMU_OP_SHR_ALG_DW_IMM) carry_ff <= sra_carry;
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    wire [31:0] status_word = {27'h0, carry_ff, cond_ff};
    logic [31:0] rd_mux;
    always_comb begin
        unique case (s_axi_araddr)
            rmu_pkg::OFS_CTRL: rd_mux = ctrl_ff;
            rmu_pkg::OFS_FIELDS: rd_mux = fields_ff;
            rmu_pkg::OFS_SRC_LO: rd_mux = src_lo_ff;
            rmu_pkg::OFS_SRC_HI: rd_mux = src_hi_ff;
            rmu_pkg::OFS_COUNT: rd_mux = count_ff;
            rmu_pkg::OFS_DEST_LO: rd_mux = dest_lo_ff;
            rmu_pkg::OFS_DEST_HI: rd_mux = dest_hi_ff;
            rmu_pkg::OFS_RES_LO: rd_mux = result_ff[31:0];
            rmu_pkg::OFS_RES_HI: rd_mux = result_ff[63:32];
            rmu_pkg::OFS_STATUS: rd_mux = status_word;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= rmu_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= mapped(s_axi_araddr) ? rmu_pkg::RESP_OKAY : rmu_pkg::RESP_SLVERR;
        end else if (r_hs) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
endmodule

// ===== rmu_pkg.sv
// Purpose: Shared constants and types for the rotate and mask unit
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: Big-endian bit numbering on the 64-bit operands
package rmu_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FIELDS = 8'h04;
    localparam logic [7:0] OFS_SRC_LO = 8'h08;
    localparam logic [7:0] OFS_SRC_HI = 8'h0C;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    localparam logic [7:0] OFS_DEST_LO = 8'h14;
    localparam logic [7:0] OFS_DEST_HI = 8'h18;
    localparam logic [7:0] OFS_RES_LO = 8'h1C;
    localparam logic [7:0] OFS_RES_HI = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    // Control word: op [3:0], record [4], mode64 [5], sum_ovf [6], go [8]
    localparam int CTRL_GO_BIT = 8;
    localparam logic [31:0] CTRL_STORE_MASK = 32'h0000007F;
    localparam logic [31:0] FIELDS_STORE_MASK = 32'h003F3F3F;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [31:0] FIELDS_RST = 32'h00000000;
    localparam logic [31:0] WORD_RST = 32'h00000000;
    localparam logic [3:0] COND_RST = 4'h0;
    localparam logic [5:0] WORD_BIAS = 6'h20;
    localparam logic [5:0] LAST_BIT = 6'h3F;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        RMU_OP_DW_IMM_CLR_LEFT = 4'h0,
        RMU_OP_DW_IMM_CLR_RIGHT = 4'h1,
        RMU_OP_DW_IMM_CLR = 4'h2,
        RMU_OP_W_IMM_AND_MASK = 4'h3,
        RMU_OP_DW_REG_CLR_LEFT = 4'h4,
        RMU_OP_DW_REG_CLR_RIGHT = 4'h5,
        RMU_OP_W_REG_AND_MASK = 4'h6,
        RMU_OP_W_IMM_INSERT = 4'h7,
        RMU_OP_DW_IMM_INSERT = 4'h8,
        RMU_OP_SHR_ALG_DW_IMM = 4'h9
    } rmu_op_t;

    typedef struct packed {
        logic [24:0] unused;
        logic sum_ovf;
        logic mode64;
        logic record;
        rmu_op_t op;
    } rmu_ctrl_t;

    typedef struct packed {
        logic [9:0] pad2;
        logic [5:0] rotate_count;
        logic [1:0] pad1;
        logic [5:0] mask_end;
        logic [1:0] pad0;
        logic [5:0] mask_begin;
    } rmu_fields_t;

    // Condition bits in big-endian order: lt, gt, eq, sum_ovf
    typedef struct packed {
        logic lt;
        logic gt;
        logic eq;
        logic so;
    } rmu_cond_t;
endpackage

// ===== rmu_props.sv
// Purpose: Port-level checks on the rotate and mask unit
// Assumes: One clock, synchronous active-low reset
// Notes: Sees only the top-level ports
`timescale 1ns/100ps
module rmu_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [rmu_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rmu_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // --------------------------------
    // Read address seen at handshake
    // --------------------------------
    logic [7:0] rd_addr_ff;
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_ff <= s_axi_araddr;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // --------------------------------
    // Assertions
    // --------------------------------
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[2:3] s_axi_bvalid) else $error("write answer late");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == rmu_pkg::RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("refused read carries data");
    unmapped_read_a: assert property (s_axi_rvalid && rd_addr_ff > rmu_pkg::OFS_STATUS
        |-> s_axi_rresp == rmu_pkg::RESP_SLVERR) else $error("unmapped read accepted");
    status_bits_a: assert property (
        s_axi_rvalid && rd_addr_ff == rmu_pkg::OFS_STATUS |-> s_axi_rdata[31:5] == 27'h0)
        else $error("status spare bits set");
    ctrl_bits_a: assert property (s_axi_rvalid && rd_addr_ff == rmu_pkg::OFS_CTRL
        |-> s_axi_rdata[31:7] == 25'h0) else $error("control spare bits set");
endmodule
bind rmu_top rmu_props u_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== rmu_host_model.sv
// Purpose: Instruction-issue side acting as bus master of the unit
// Assumes: One write and one read under way at most
// Notes: Ready rises late; released payload is inverted
`timescale 1ns/100ps
module rmu_host_model (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        wstrb = 4'hF;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
            if (bvalid) bready <= 1'b1;
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_ok;
        ar_ok = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
            if (rvalid) rready <= 1'b1;
            if (!ar_ok && arready) begin
                ar_ok = 1'b1;
                arvalid <= 1'b0;
                araddr <= ~a;
            end
        end
    endtask
endmodule

// ===== tb_rotate_mask_unit.sv
// Purpose: Self-checking bench of the rotate and mask unit
// Assumes: Fixed seed, reference model in bench functions
// Notes: Bit position p is vector index 63-p
`timescale 1ns/100ps
module tb_rotate_mask_unit;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, cnt, t;
    logic [3:0] wstrb, op;
    logic [1:0] bresp, rresp;
    logic [63:0] src, dst, res_m;
    logic [5:0] mb, me, sh;
    logic rec, m64, so;
    logic [4:0] st_m;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    initial aclk = 1'b0;
    always #2.5 aclk = ~aclk;
    rmu_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    rmu_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    // --------------------------------
    // Reference model and checks
    // --------------------------------
    function automatic logic [63:0] mk(input int b, input int e);
        logic [63:0] m;
        m = '0;
        for (int p = 0; p < 64; p++) begin
            if (b <= e ? (p >= b && p <= e) : (p >= b || p <= e)) begin
                m[63-p] = 1'b1;
            end
        end
        return m;
    endfunction
    function automatic logic [63:0] rl(input logic [63:0] x, input int n);
        logic [127:0] y;
        y = {x, x} << n;
        return y[127:64];
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic [1:0] r;
        host.wr(a, d, r);
        chk(r, e);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        chk(r, er);
        chk(d, e);
    endtask
    task automatic rnd();
        {src, dst} = {$urandom, $urandom, $urandom, $urandom};
        cnt = $urandom;
        t = $urandom;
        {mb, me, sh, rec, m64, so} = t[20:0];
    endtask
    task automatic run_op();
        logic [63:0] r, m, dw;
        logic signed [63:0] v;
        dw = {src[31:0], src[31:0]};
        r = '0;
        m = '0;
        case (op)
            4'd0, 4'd4: m = mk(mb, 63);
            4'd1, 4'd5: m = mk(0, me);
            4'd2, 4'd8: m = mk(mb, 63 - sh);
            4'd3, 4'd6, 4'd7: m = mk(mb[4:0] + 32, me[4:0] + 32);
            default: m = '0;
        endcase
        if (op == 4'd4 || op == 4'd5) begin
            r = rl(src, cnt[5:0]);
        end else if (op == 4'd6) begin
            r = rl(dw, cnt[4:0]);
        end else begin
            r = (op == 4'd3 || op == 4'd7) ? rl(dw, sh[4:0]) : rl(src, sh);
        end
        wc(rmu_pkg::OFS_FIELDS, {10'h0, sh, 2'h0, me, 2'h0, mb}, rmu_pkg::RESP_OKAY);
        wc(rmu_pkg::OFS_SRC_LO, src[31:0], rmu_pkg::RESP_OKAY);
        wc(rmu_pkg::OFS_SRC_HI, src[63:32], rmu_pkg::RESP_OKAY);
        wc(rmu_pkg::OFS_COUNT, cnt, rmu_pkg::RESP_OKAY);
        wc(rmu_pkg::OFS_DEST_LO, dst[31:0], rmu_pkg::RESP_OKAY);
        wc(rmu_pkg::OFS_DEST_HI, dst[63:32], rmu_pkg::RESP_OKAY);
        wc(rmu_pkg::OFS_CTRL, {23'h0, 1'b1, 1'b0, so, m64, rec, op}, rmu_pkg::RESP_OKAY);
        if (op < 4'd10) begin
            res_m = (op == 4'd7 || op == 4'd8) ? ((r & m) | (dst & ~m)) : (r & m);
            if (op == 4'd9) begin
                res_m = $signed(src) >>> sh;
                st_m[4] = src[63] && ((src & ((64'h1 << sh) - 64'h1)) != 64'h0);
            end
            v = m64 ? res_m : {{32{res_m[31]}}, res_m[31:0]};
            if (rec) begin
                st_m[3:0] = {v < 0, v > 0, v == 0, so};
            end
        end
        rc(rmu_pkg::OFS_RES_LO, res_m[31:0], rmu_pkg::RESP_OKAY);
        rc(rmu_pkg::OFS_RES_HI, res_m[63:32], rmu_pkg::RESP_OKAY);
        rc(rmu_pkg::OFS_STATUS, {27'h0, st_m}, rmu_pkg::RESP_OKAY);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // --------------------------------
    // Sequence and hang guard
    // --------------------------------
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            $display("[FAIL] %0t run timed out", $time);
            close_out();
        end
    end
    initial begin
        aresetn = 1'b0;
        res_m = '0;
        st_m = '0;
        void'($urandom(32'h9F5C));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rc(rmu_pkg::OFS_CTRL, 32'h0, rmu_pkg::RESP_OKAY);
        rc(rmu_pkg::OFS_STATUS, 32'h0, rmu_pkg::RESP_OKAY);
        t = $urandom;
        wc(rmu_pkg::OFS_CTRL, {t[31:9], 1'b0, t[7:0]}, rmu_pkg::RESP_OKAY);
        rc(rmu_pkg::OFS_CTRL, t & rmu_pkg::CTRL_STORE_MASK, rmu_pkg::RESP_OKAY);
        wc(rmu_pkg::OFS_FIELDS, t, rmu_pkg::RESP_OKAY);
        rc(rmu_pkg::OFS_FIELDS, t & rmu_pkg::FIELDS_STORE_MASK, rmu_pkg::RESP_OKAY);
        wc(rmu_pkg::OFS_RES_LO, t, rmu_pkg::RESP_OKAY);
        rc(rmu_pkg::OFS_RES_LO, 32'h0, rmu_pkg::RESP_OKAY);
        wc(8'h40, t, rmu_pkg::RESP_SLVERR);
        rc(8'h40, 32'h0, rmu_pkg::RESP_SLVERR);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            rnd();
            op = i[3:0];
            run_op();
        end
        $display("test every opcode done");
        // Negative source: carry must not follow the mode bit
        for (int i = 0; i < 4; i++) begin
            rnd();
            src = 64'h8000_0000_0000_0001;
            op = 4'd9;
            sh = i[1] ? 6'h00 : 6'h01;
            m64 = i[0];
            run_op();
        end
        $display("test carry modes done");
        repeat (200) begin
            rnd();
            t = $urandom_range(0, 11);
            op = t[3:0];
            run_op();
        end
        $display("test random done");
        close_out();
    end
endmodule
